// ### include/dcv_params.svh
`ifndef DCV_PARAMS_SVH
`define DCV_PARAMS_SVH

`define DCV_A_CTRL 12'h000
`define DCV_A_NCOA 12'h004
`define DCV_A_NCOB 12'h008
`define DCV_A_CMD 12'h00C
`define DCV_A_STAT 12'h010

`define DCV_B_EN 0
`define DCV_B_REAL 1
`define DCV_B_FS4 2
`define DCV_B_GAIN 3
`define DCV_B_INV 4
`define DCV_B_PINAL 5
`define DCV_B_SWAP 6
`define DCV_B_DSEL_LO 8
`define DCV_B_DSEL_HI 10
`define DCV_B_RES_LO 12
`define DCV_B_RES_HI 13
`define DCV_B_RELOAD 0
`define DCV_B_ALIGN 1
`define DCV_B_ALIGNED 0
`define DCV_B_CNT_LO 8
`define DCV_B_CNT_HI 12

`define DCV_CTRL_RST 32'h0000_0000
`define DCV_NCO_RST 32'h0000_0000
`define DCV_DSEL_MAX 3'h4

`define DCV_NSTG 5
`define DCV_NTAP 7
`define DCV_PAD 6'h00
`define DCV_C_SIDE 25'sh0000009
`define DCV_C_CTR_SH 4
`define DCV_C_NORM_SH 5

`define DCV_M14 20'hFFFC0
`define DCV_M16 20'hFFFF0
`define DCV_M18 20'hFFFFC
`define DCV_M20 20'hFFFFF

`define DCV_PH_HI 31
`define DCV_PH_LO 26
`define DCV_QTR 6'h10
`define DCV_PR_HI 28
`define DCV_PR_LO 9
`define DCV_SAT_MAX 22'sh07FFFF
`define DCV_SAT_MIN 22'sh380000

`endif

// ### include/dcv_pkg.sv
package dcv_pkg;
	typedef logic signed [19:0] dcv_smp_t;
	typedef enum logic [1:0] {
		DCV_RES14 = 2'b00,
		DCV_RES16 = 2'b01,
		DCV_RES18 = 2'b10,
		DCV_RES20 = 2'b11
	} dcv_res_e;
	typedef enum logic [1:0] {
		DCV_ROT0 = 2'b00,
		DCV_ROT1 = 2'b01,
		DCV_ROT2 = 2'b10,
		DCV_ROT3 = 2'b11
	} dcv_rot_e;
endpackage

// ### include/dcv_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dcv_cfg_if;
	logic       real_mode;
	logic       invert;
	logic       gain_en;
	logic       reload;
	logic [5:0] stb;
	logic [2:0] dsel;
	modport ctl  (output real_mode, invert, gain_en, reload, stb, dsel);
	modport nco  (input real_mode, invert, reload);
	modport filt (input real_mode, gain_en, stb, dsel);
endinterface
`default_nettype wire

// ### core/dcv_nco.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcv_params.svh"
module dcv_nco (
	dcv_cfg_if.nco                cfg,
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [31:0]      freq_word,
	input  wire logic signed [13:0] smp,
	output dcv_pkg::dcv_smp_t     mix_i,
	output dcv_pkg::dcv_smp_t     mix_q
);
	import dcv_pkg::*;

	logic [31:0]        inc_ff;
	logic [31:0]        phase_ff;
	logic signed [15:0] s_w;
	logic signed [15:0] c_w;
	logic signed [15:0] sq_w;
	logic signed [29:0] pi_w;
	logic signed [29:0] pq_w;

	// quarter-wave table on exact steps: word 0 gives Q of zero
	function automatic logic signed [15:0] sin_lut(input logic [5:0] p);
		logic [4:0]  idx;
		logic [15:0] m;
		idx = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
		case (idx)
			5'h00: m = 16'h0000;
			5'h01: m = 16'h0C8C;
			5'h02: m = 16'h18F9;
			5'h03: m = 16'h2528;
			5'h04: m = 16'h30FB;
			5'h05: m = 16'h3C56;
			5'h06: m = 16'h471C;
			5'h07: m = 16'h5133;
			5'h08: m = 16'h5A82;
			5'h09: m = 16'h62F1;
			5'h0A: m = 16'h6A6D;
			5'h0B: m = 16'h70E2;
			5'h0C: m = 16'h7641;
			5'h0D: m = 16'h7A7C;
			5'h0E: m = 16'h7D89;
			5'h0F: m = 16'h7F61;
			default: m = 16'h7FFF;
		endcase
		return p[5] ? -$signed(m) : $signed(m);
	endfunction

	// new word only takes effect on reload, phase restarts at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inc_ff   <= `DCV_NCO_RST;
			phase_ff <= `DCV_NCO_RST;
		end else if (cfg.reload) begin
			inc_ff   <= freq_word;
			phase_ff <= `DCV_NCO_RST;
		end else begin
			phase_ff <= phase_ff + inc_ff;
		end
	end

	assign s_w  = sin_lut(phase_ff[`DCV_PH_HI:`DCV_PH_LO]);
	assign c_w  = sin_lut(phase_ff[`DCV_PH_HI:`DCV_PH_LO] + `DCV_QTR);
	assign sq_w = cfg.invert ? -s_w : s_w;
	assign pi_w = smp * c_w;
	assign pq_w = smp * sq_w;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mix_i <= '0;
			mix_q <= '0;
		end else if (cfg.real_mode) begin
			mix_i <= {smp, `DCV_PAD};
			mix_q <= '0;
		end else begin
			mix_i <= pi_w[`DCV_PR_HI:`DCV_PR_LO];
			mix_q <= pq_w[`DCV_PR_HI:`DCV_PR_LO];
		end
	end
endmodule // dcv_nco
`default_nettype wire

// ### core/dcv_decim.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcv_params.svh"
module dcv_decim (
	dcv_cfg_if.filt           cfg,
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  dcv_pkg::dcv_smp_t din_i,
	input  dcv_pkg::dcv_smp_t din_q,
	output dcv_pkg::dcv_smp_t dout_i,
	output dcv_pkg::dcv_smp_t dout_q
);
	import dcv_pkg::*;

	dcv_smp_t tap [2][`DCV_NSTG][`DCV_NTAP];
	dcv_smp_t so  [2][`DCV_NSTG];
	dcv_smp_t y   [2][`DCV_NSTG];
	dcv_smp_t din [2];
	dcv_smp_t dout[2];

	assign din[0] = din_i;
	assign din[1] = din_q;
	assign dout_i = dout[0];
	assign dout_q = dout[1];

	// 6 dB complex, about 3 dB real, saturating to 20 bits
	function automatic dcv_smp_t gain(input dcv_smp_t x, input logic rl);
		logic signed [21:0] v;
		v = rl ? (22'(x) + 22'(x >>> 2) + 22'(x >>> 3) + 22'(x >>> 5))
		       : (22'(x) <<< 1);
		if (v > `DCV_SAT_MAX)
			v = `DCV_SAT_MAX;
		else if (v < `DCV_SAT_MIN)
			v = `DCV_SAT_MIN;
		return v[19:0];
	endfunction

	// cascaded 7-tap half-band stages, each halves the rate
	for (genvar l = 0; l < 2; l++) begin : g_lane
		for (genvar k = 0; k < `DCV_NSTG; k++) begin : g_stg
			logic signed [24:0] acc_w;
			dcv_smp_t           src_w;
			if (k == 0) begin : g_first
				assign src_w = din[l];
			end else begin : g_next
				assign src_w = so[l][k-1];
			end
			assign acc_w = (25'(tap[l][k][2]) + 25'(tap[l][k][4]))
				* `DCV_C_SIDE
				- 25'(tap[l][k][0]) - 25'(tap[l][k][6])
				+ (25'(tap[l][k][3]) <<< `DCV_C_CTR_SH);
			assign y[l][k] = acc_w[`DCV_C_NORM_SH +: 20];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tap[l][k] <= '{default: '0};
				end else if (cfg.stb[k]) begin
					tap[l][k][0] <= src_w;
					for (int t = 1; t < `DCV_NTAP; t++)
						tap[l][k][t] <= tap[l][k][t-1];
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					so[l][k] <= '0;
				else if (cfg.stb[k+1])
					so[l][k] <= y[l][k];
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				dout[l] <= '0;
			else if (cfg.stb[cfg.dsel + 3'd1]) begin
				if (cfg.gain_en)
					dout[l] <= gain(y[l][cfg.dsel], cfg.real_mode);
				else
					dout[l] <= y[l][cfg.dsel];
			end
		end
	end
endmodule // dcv_decim
`default_nettype wire

// ### core/dcv_top.sv
// Functional notes
// - complex decimation 2..32 with 32-bit oscillator
// - real mode bypasses the mixer
// - filter math kept at 20 bits
// - optional channel swap into converter paths
// - complex: shift, low-pass, then decimate
// - optional 6 dB gain in complex mode
// - optional 3 dB gain in real mode
// - real mode: no shift, real half only
// - quarter-rate mix gives real output, double rate
// - mixer phase inversion selectable
// - real samples times signed-frequency exponential
// - new frequency waits for reload or alignment
// - about 80 percent passband, deep stopband
// - pin becomes alignment input, sampled on clock
// - alignment resets dividers, aligns I and Q
// - alignment also reloads oscillator, clears phase
// - alignment from register trigger or pin
// - output truncated to 14..20 bit resolution
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "dcv_params.svh"
module dcv_top (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic [13:0]  adc_a_smp,
	input  wire logic [13:0]  adc_b_smp,
	input  wire logic         powerdown_align_pin,
	output logic              powerdown_req,
	output dcv_pkg::dcv_smp_t out_a_i,
	output dcv_pkg::dcv_smp_t out_a_q,
	output dcv_pkg::dcv_smp_t out_b_i,
	output dcv_pkg::dcv_smp_t out_b_q,
	output logic              out_valid
);
	import dcv_pkg::*;

	dcv_cfg_if cfg ();

	logic [31:0] ctrl_ff;
	logic [31:0] nco_ff [2];
	logic [1:0]  cmd_ff;
	logic        aligned_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        pin_s1_ff;
	logic        pin_s2_ff;
	logic        pin_s3_ff;
	logic        pdn_ff;
	logic        reload_ff;
	logic        align_ff;
	logic [4:0]  cnt_ff;
	logic        cplx_d_ff;
	logic        half_d_ff;
	logic        valid_ff;
	dcv_rot_e    rot_ff;
	dcv_rot_e    nxt_rot;
	dcv_smp_t    oi_ff [2];
	dcv_smp_t    oq_ff [2];

	logic        wr_w;
	logic        setup_w;
	logic        hit_w;
	logic [31:0] rd_w;
	logic        sw_align_w;
	logic        sw_reload_w;
	logic        pin_align_w;
	logic [2:0]  dsel_w;
	logic        en_w;
	logic        fs4_w;
	dcv_res_e    res_w;
	dcv_smp_t    mask_w;
	logic [13:0] adc_w [2];
	dcv_smp_t    mi_w [2];
	dcv_smp_t    mq_w [2];
	dcv_smp_t    di_w [2];
	dcv_smp_t    dq_w [2];

	assign setup_w = psel & ~penable;
	assign wr_w    = psel & penable & pready_ff & pwrite;
	assign en_w    = ctrl_ff[`DCV_B_EN];
	assign fs4_w   = ctrl_ff[`DCV_B_FS4] & ~ctrl_ff[`DCV_B_REAL];
	assign dsel_w  = ctrl_ff[`DCV_B_DSEL_HI:`DCV_B_DSEL_LO];
	assign res_w   = dcv_res_e'(ctrl_ff[`DCV_B_RES_HI:`DCV_B_RES_LO]);
	assign adc_w[0] = adc_a_smp;
	assign adc_w[1] = adc_b_smp;

	always_comb begin
		hit_w = 1'b1;
		rd_w  = '0;
		case (paddr)
			`DCV_A_CTRL: rd_w = ctrl_ff;
			`DCV_A_NCOA: rd_w = nco_ff[0];
			`DCV_A_NCOB: rd_w = nco_ff[1];
			`DCV_A_CMD:  rd_w = {30'h0, cmd_ff};
			`DCV_A_STAT: begin
				rd_w[`DCV_B_ALIGNED] = aligned_ff;
				rd_w[`DCV_B_CNT_HI:`DCV_B_CNT_LO] = cnt_ff;
			end
			default: hit_w = 1'b0;
		endcase
	end

	// zero-wait slave: answer prepared during the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			pready_ff  <= setup_w;
			pslverr_ff <= setup_w & ~hit_w;
			if (setup_w)
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_w;
		end
	end

	// decimation select above 4 (ratio 32) is clamped to 4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_ff <= `DCV_CTRL_RST;
		else if (wr_w && paddr == `DCV_A_CTRL) begin
			ctrl_ff <= pwdata;
			if (pwdata[`DCV_B_DSEL_HI:`DCV_B_DSEL_LO] > `DCV_DSEL_MAX)
				ctrl_ff[`DCV_B_DSEL_HI:`DCV_B_DSEL_LO] <= `DCV_DSEL_MAX;
		end
	end

	// pending frequency words, loaded into the oscillators later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nco_ff[0] <= `DCV_NCO_RST;
			nco_ff[1] <= `DCV_NCO_RST;
		end else if (wr_w && paddr == `DCV_A_NCOA) begin
			nco_ff[0] <= pwdata;
		end else if (wr_w && paddr == `DCV_A_NCOB) begin
			nco_ff[1] <= pwdata;
		end
	end

	// a change of either command bit is the trigger
	assign sw_reload_w = wr_w && paddr == `DCV_A_CMD
		&& pwdata[`DCV_B_RELOAD] != cmd_ff[`DCV_B_RELOAD];
	assign sw_align_w  = wr_w && paddr == `DCV_A_CMD
		&& pwdata[`DCV_B_ALIGN] != cmd_ff[`DCV_B_ALIGN];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_ff <= 2'h0;
		else if (wr_w && paddr == `DCV_A_CMD)
			cmd_ff <= pwdata[`DCV_B_ALIGN:`DCV_B_RELOAD];
	end

	// pin is asynchronous to pclk: two stages before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_s3_ff <= 1'b0;
		end else begin
			pin_s1_ff <= powerdown_align_pin;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	assign pin_align_w = ctrl_ff[`DCV_B_PINAL]
		& pin_s2_ff & ~pin_s3_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pdn_ff <= 1'b0;
		else
			pdn_ff <= ~ctrl_ff[`DCV_B_PINAL] & pin_s2_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			align_ff  <= 1'b0;
			reload_ff <= 1'b0;
		end else begin
			align_ff  <= sw_align_w | pin_align_w;
			reload_ff <= sw_reload_w | sw_align_w | pin_align_w;
		end
	end

	// divider phase is arbitrary until the first alignment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_ff <= 5'h00;
		else if (align_ff)
			cnt_ff <= 5'h00;
		else
			cnt_ff <= cnt_ff + 5'h01;
	end

	// set wins over a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			aligned_ff <= 1'b0;
		else if (align_ff)
			aligned_ff <= 1'b1;
		else if (wr_w && paddr == `DCV_A_STAT && pwdata[`DCV_B_ALIGNED])
			aligned_ff <= 1'b0;
	end

	assign cfg.stb[0]    = 1'b1;
	for (genvar k = 1; k < 6; k++) begin : g_stb
		assign cfg.stb[k] = &cnt_ff[k-1:0];
	end
	assign cfg.real_mode = ctrl_ff[`DCV_B_REAL];
	assign cfg.invert    = ctrl_ff[`DCV_B_INV];
	assign cfg.gain_en   = ctrl_ff[`DCV_B_GAIN];
	assign cfg.reload    = reload_ff;
	assign cfg.dsel      = dsel_w;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [13:0] src_w;
		assign src_w = ctrl_ff[`DCV_B_SWAP] ? adc_w[1-c] : adc_w[c];
		dcv_nco u_nco (
			.cfg       (cfg),
			.pclk      (pclk),
			.presetn   (presetn),
			.freq_word (nco_ff[c]),
			.smp       (src_w),
			.mix_i     (mi_w[c]),
			.mix_q     (mq_w[c])
		);
		dcv_decim u_decim (
			.cfg     (cfg),
			.pclk    (pclk),
			.presetn (presetn),
			.din_i   (mi_w[c]),
			.din_q   (mq_w[c]),
			.dout_i  (di_w[c]),
			.dout_q  (dq_w[c])
		);
	end

	// filter output lands one cycle after its divider strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cplx_d_ff <= 1'b0;
			half_d_ff <= 1'b0;
		end else begin
			cplx_d_ff <= cfg.stb[dsel_w + 3'd1];
			half_d_ff <= cfg.stb[dsel_w] & ~cfg.stb[dsel_w + 3'd1];
		end
	end

	// quarter-rate rotation: I, -Q, -I, Q
	always_comb begin
		nxt_rot = rot_ff;
		case (rot_ff)
			DCV_ROT0: if (cplx_d_ff) nxt_rot = DCV_ROT1;
			DCV_ROT1: if (half_d_ff) nxt_rot = DCV_ROT2;
			DCV_ROT2: if (cplx_d_ff) nxt_rot = DCV_ROT3;
			DCV_ROT3: if (half_d_ff) nxt_rot = DCV_ROT0;
			default:  nxt_rot = DCV_ROT0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rot_ff <= DCV_ROT0;
		else if (!fs4_w || align_ff)
			rot_ff <= DCV_ROT0;
		else
			rot_ff <= nxt_rot;
	end

	always_comb begin
		case (res_w)
			DCV_RES14: mask_w = `DCV_M14;
			DCV_RES16: mask_w = `DCV_M16;
			DCV_RES18: mask_w = `DCV_M18;
			default:   mask_w = `DCV_M20;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			valid_ff <= 1'b0;
		else if (!en_w)
			valid_ff <= 1'b1;
		else if (fs4_w)
			valid_ff <= cplx_d_ff | half_d_ff;
		else
			valid_ff <= cplx_d_ff;
	end

	for (genvar c = 0; c < 2; c++) begin : g_out
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				oi_ff[c] <= '0;
				oq_ff[c] <= '0;
			end else if (!en_w) begin
				oi_ff[c] <= {adc_w[c], `DCV_PAD} & mask_w;
				oq_ff[c] <= '0;
			end else if (fs4_w) begin
				oq_ff[c] <= '0;
				if (cplx_d_ff && rot_ff == DCV_ROT0)
					oi_ff[c] <= di_w[c] & mask_w;
				else if (half_d_ff && rot_ff == DCV_ROT1)
					oi_ff[c] <= (-dq_w[c]) & mask_w;
				else if (cplx_d_ff && rot_ff == DCV_ROT2)
					oi_ff[c] <= (-di_w[c]) & mask_w;
				else if (half_d_ff && rot_ff == DCV_ROT3)
					oi_ff[c] <= dq_w[c] & mask_w;
			end else if (cplx_d_ff) begin
				oi_ff[c] <= di_w[c] & mask_w;
				oq_ff[c] <= dq_w[c] & mask_w;
			end
		end
	end

	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign powerdown_req = pdn_ff;
	assign out_valid     = valid_ff;
	assign out_a_i       = oi_ff[0];
	assign out_a_q       = oq_ff[0];
	assign out_b_i       = oi_ff[1];
	assign out_b_q       = oq_ff[1];
endmodule // dcv_top
`default_nettype wire

// ### tb/dcv_host_sink.sv
`timescale 1ns/1ns
`default_nettype none
module dcv_host_sink (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic out_valid,
	output var  int   count
);
	int cnt_ff;

	// a receiving port takes a word on every valid cycle, no back-pressure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_ff <= 0;
		else if (out_valid)
			cnt_ff <= cnt_ff + 1;
	end
	assign count = cnt_ff;
endmodule // dcv_host_sink
`default_nettype wire

// ### tb/dcv_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dcv_chk (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [13:0]       adc_a_smp,
	input wire logic [13:0]       adc_b_smp,
	input wire logic              powerdown_align_pin,
	input wire logic              powerdown_req,
	input wire dcv_pkg::dcv_smp_t out_a_i,
	input wire dcv_pkg::dcv_smp_t out_a_q,
	input wire dcv_pkg::dcv_smp_t out_b_i,
	input wire dcv_pkg::dcv_smp_t out_b_q,
	input wire logic              out_valid
);
	import dcv_pkg::*;
	logic [31:0] ctrl_ff;
	logic [31:0] nco_ff;
	logic [5:0]  settle_ff;
	logic [5:0]  gap_ff;
	logic        pin_ff;
	logic [5:0]  ndec;
	logic        wr;
	logic        settled;
	logic        unmapped;

	assign wr = psel && penable && pready && pwrite;
	assign settled = settle_ff == 6'h3F;
	assign unmapped = !(paddr inside {12'h000, 12'h004, 12'h008,
		12'h00C, 12'h010});
	assign ndec = (ctrl_ff[10:8] > 3'h4) ? 6'h20 : 6'(6'h02 << ctrl_ff[10:8]);

	// shadow of the control words, so checks follow what software set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_ff <= 32'h0;
		else if (wr && paddr == 12'h000)
			ctrl_ff <= pwdata;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			nco_ff <= 32'h0;
		else if (wr && paddr == 12'h004)
			nco_ff <= pwdata;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_ff <= 1'b0;
		else
			pin_ff <= powerdown_align_pin;
	end
	// any mode change or alignment restarts the settling window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle_ff <= 6'h00;
		else if (wr && (paddr == 12'h000 || paddr == 12'h00C))
			settle_ff <= 6'h00;
		else if (pin_ff != powerdown_align_pin)
			settle_ff <= 6'h00;
		else if (!settled)
			settle_ff <= settle_ff + 6'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap_ff <= 6'h00;
		else if (out_valid)
			gap_ff <= 6'h00;
		else if (gap_ff != 6'h3F)
			gap_ff <= gap_ff + 6'h01;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	apb_phase_a: assert property (pready |-> psel && penable ##1 !pready)
		else $error("ready outside one access cycle");
	apb_err_a: assert property (pready |-> pslverr == unmapped)
		else $error("error flag does not match address map");
	nco_read_a: assert property (pready && !pwrite && paddr == 12'h004
		|-> prdata == nco_ff)
		else $error("frequency word readback wrong");
	bypass_rate_a: assert property (!ctrl_ff[0] && settled |-> out_valid)
		else $error("bypass sample missing");
	bypass_data_a: assert property (!ctrl_ff[0] && settled
		&& ctrl_ff[13:12] == 2'b00 |-> out_a_i == {$past(adc_a_smp), 6'h00}
		&& out_b_i == {$past(adc_b_smp), 6'h00})
		else $error("bypass data wrong");
	real_q_a: assert property (ctrl_ff[1:0] == 2'b11 && settled
		|-> out_a_q == 20'h0 && out_b_q == 20'h0)
		else $error("real mode quadrature not zero");
	decim_gap_a: assert property (ctrl_ff[0] && !ctrl_ff[2] && settled
		&& out_valid |-> gap_ff == ndec - 6'h01)
		else $error("decimated output spacing wrong");
	quarter_gap_a: assert property (ctrl_ff[2:0] == 3'b101 && settled
		&& out_valid |-> gap_ff == (ndec >> 1) - 6'h01)
		else $error("quarter-rate output spacing wrong");
	pdn_follow_a: assert property (!ctrl_ff[5]
		&& $rose(powerdown_align_pin) |-> ##[1:4] powerdown_req)
		else $error("power-down request missing");
	pdn_off_a: assert property (ctrl_ff[5] && $past(ctrl_ff[5], 2)
		|-> !powerdown_req)
		else $error("power-down while pin aligns");
endmodule // dcv_chk

bind dcv_top dcv_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.adc_a_smp(adc_a_smp), .adc_b_smp(adc_b_smp),
	.powerdown_align_pin(powerdown_align_pin),
	.powerdown_req(powerdown_req), .out_a_i(out_a_i), .out_a_q(out_a_q),
	.out_b_i(out_b_i), .out_b_q(out_b_q), .out_valid(out_valid));
`default_nettype wire

// ### tb/decimating_down_converter_test.sv
`timescale 1ns/1ns
`default_nettype none
module decimating_down_converter_test;
	import dcv_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pin, pready, pslverr;
	logic        pdn_req, out_valid, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] adc_a, adc_b;
	dcv_smp_t    a_i, a_q, b_i, b_q, q0;
	int          n_errors, n_checks, host_cnt, c0, i;
	logic [31:0] gx [4] = '{32'h2300, 32'h2320, 32'h2328, 32'h2328};

	dcv_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_a_smp(adc_a), .adc_b_smp(adc_b), .powerdown_align_pin(pin),
		.powerdown_req(pdn_req), .out_a_i(a_i), .out_a_q(a_q),
		.out_b_i(b_i), .out_b_q(b_q), .out_valid(out_valid));
	dcv_host_sink host_u (.pclk(pclk), .presetn(presetn),
		.out_valid(out_valid), .count(host_cnt));

	initial begin
		forever #4 pclk = ~pclk;
	end

	function automatic logic [31:0] sx(input logic [19:0] v);
		return {{12{v[19]}}, v};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// look at ready mid-cycle, then act on the edge that samples it
		@(negedge pclk);
		while (pready !== 1'b1 && t < 20) begin
			@(negedge pclk);
			t++;
		end
		if (t == 20)
			n_errors++;
		@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [11:0] a,
		input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd & m, exp);
	endtask

	// bounded wait for k output words
	task automatic waitv(input int k);
		int t;
		t = 0;
		repeat (k) begin
			@(posedge pclk);
			while (out_valid !== 1'b1 && t < 2000) begin
				@(posedge pclk);
				t++;
			end
		end
		if (t >= 2000)
			n_errors++;
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#320000;
		n_errors++;
		give_verdict();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, pin} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		adc_a = 14'h0064;
		adc_b = 14'h3F38;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ctrl_rst", 12'h000, 32'hFFFFFFFF, 32'h0);
		rchk("ncoa_rst", 12'h004, 32'hFFFFFFFF, 32'h0);
		rchk("ncob_rst", 12'h008, 32'hFFFFFFFF, 32'h0);
		rchk("stat_rst", 12'h010, 32'h1, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk("unmapped_err", {31'h0, err}, 32'h1);
		chk("unmapped_rd", rd, 32'h0);
		// ramp keeps the bypass data check honest
		for (i = 0; i < 80; i++) begin
			@(posedge pclk);
			adc_a <= adc_a + 14'h0001;
		end
		repeat (3) @(posedge pclk);
		chk("bypass_a", sx(a_i), sx({adc_a, 6'h00}));
		adc_a <= 14'h0064;
		apb(1'b1, 12'h000, 32'h3003);
		waitv(24);
		chk("real_a", sx(a_i), 32'h1900);
		chk("real_b", sx(b_i), 32'hFFFFCE00);
		chk("real_q", sx(a_q), 32'h0);
		apb(1'b1, 12'h000, 32'h3043);
		waitv(24);
		chk("swap_a", sx(a_i), 32'hFFFFCE00);
		chk("swap_b", sx(b_i), 32'h1900);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, 32'h000B | (i << 12));
			waitv(24);
			chk("gain_res", sx(a_i), gx[i]);
		end
		// setting 5 must behave as 4
		for (i = 0; i < 6; i++) begin
			apb(1'b1, 12'h000, 32'h3003 | (i << 8));
			waitv(3);
			c0 = host_cnt;
			repeat (128) @(posedge pclk);
			chk("rate", host_cnt - c0, 128 >> ((i > 4 ? 4 : i) + 1));
		end
		apb(1'b1, 12'h000, 32'h3205);
		waitv(3);
		c0 = host_cnt;
		repeat (128) @(posedge pclk);
		chk("quarter_rate", host_cnt - c0, 32'd32);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h00C, 32'h1);
		apb(1'b1, 12'h000, 32'h3001);
		waitv(24);
		chk("nco0_q", sx(a_q), 32'h0);
		apb(1'b1, 12'h004, 32'h2000_0000);
		waitv(24);
		chk("pending_q", sx(a_q), 32'h0);
		apb(1'b1, 12'h00C, 32'h0);
		waitv(24);
		q0 = a_q;
		waitv(1);
		chk("shift_q", {31'h0, q0 != 0 || a_q != 0}, 32'h1);
		apb(1'b1, 12'h010, 32'h1);
		apb(1'b1, 12'h000, 32'h3023);
		rchk("stat_clr", 12'h010, 32'h1, 32'h0);
		pin <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("pdn_off", {31'h0, pdn_req}, 32'h0);
		rchk("pin_align", 12'h010, 32'h1, 32'h1);
		apb(1'b1, 12'h010, 32'h1);
		rchk("stat_clr2", 12'h010, 32'h1, 32'h0);
		apb(1'b1, 12'h00C, 32'h2);
		repeat (2) @(posedge pclk);
		rchk("reg_align", 12'h010, 32'h1, 32'h1);
		pin <= 1'b0;
		apb(1'b1, 12'h000, 32'h3003);
		@(posedge pclk);
		pin <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("pdn_on", {31'h0, pdn_req}, 32'h1);
		give_verdict();
	end
endmodule // decimating_down_converter_test
`default_nettype wire
